/* fpf_cpu_model.sv */
// CPU data-path model issuing one-cycle flash data accesses
`timescale 1ns/1ps
module fpf_cpu_model (
  // System
  input wire clock,
  // Data access
  output reg acc_req = 1'b0,
  output reg acc_in_flash = 1'b0,
  output reg acc_is_read = 1'b0,
  output reg fetch_in_flash = 1'b0
);
  task access(input f, input r);
    @(posedge clock);
    acc_req <= 1'b1;
    acc_in_flash <= 1'b1;
    acc_is_read <= r;
    // Set-up code runs from RAM unless a test fetches from flash
    fetch_in_flash <= f;
    @(posedge clock);
    acc_req <= 1'b0;
    // Released qualifiers flip, so a stale value is never trusted
    acc_in_flash <= 1'b0;
    acc_is_read <= ~r;
    fetch_in_flash <= ~f;
  endtask
endmodule

/* fpf_fuse_cell.v */
// One 16-bit fuse word with its volatile copy
`timescale 1ns/1ps
`include "fpf_map.vh"
module fpf_fuse_cell #(
  parameter W = 16,
  parameter [15:0] INIT = 16'hFFFF
) (
  // System
  input wire clock,
  input wire rst,
  // Control
  input wire load,
  input wire prog,
  input wire temp,
  input wire [W-1:0] prog_mask,
  input wire [W-1:0] temp_data,
  // State
  output reg [W-1:0] fuse_reg,
  output reg [W-1:0] vol_reg
);
  always @(posedge clock) begin
    if (rst) begin
      vol_reg <= {W{1'b0}};
    end else if (load) begin
      vol_reg <= fuse_reg;
    end else if (prog) begin
      vol_reg <= vol_reg & ~prog_mask;
    end else if (temp) begin
      vol_reg <= vol_reg | temp_data;
    end
  end
  // Fuse cells survive reset; only programming clears bits, never sets them
  initial fuse_reg = INIT;
  always @(posedge clock) begin
    if (prog) begin
      fuse_reg <= fuse_reg & ~prog_mask;
    end
  end
endmodule

/* fpf_map.vh */
// Register offsets, field positions and reset values of the flash protection logic
`ifndef FPF_MAP_VH
`define FPF_MAP_VH
`define FPF_ADDR_W 24
`define FPF_OFF_WPL_ALIAS 24'h0EDFB0
`define FPF_OFF_WPH_ALIAS 24'h0EDFB2
`define FPF_OFF_WPL 24'h0EDFB4
`define FPF_OFF_WPH 24'h0EDFB6
`define FPF_OFF_APM 24'h0EDFB8
`define FPF_OFF_APD 24'h0EDFBC
`define FPF_OFF_APE 24'h0EDFBE
`define FPF_OFF_CTRL 24'h0EDFC0
`define FPF_OFF_STAT 24'h0EDFC2
`define FPF_OFF_CMD 24'h0EDFC4
`define FPF_CTRL_BUSY_BIT 1
`define FPF_STAT_WPERR_BIT 0
`define FPF_STAT_ACCERR_BIT 1
`define FPF_STAT_DBGEN_BIT 2
`define FPF_STAT_ACCEFF_BIT 3
`define FPF_CMD_PROG_BIT 0
`define FPF_CMD_TEMP_BIT 1
`define FPF_APM_ACC_FUSE_BIT 0
`define FPF_APM_DBG_FUSE_BIT 1
`define FPF_ALL_ONES 16'hFFFF
`define FPF_ALL_ZERO 16'h0000
`define FPF_WPL_RO_MASK 16'h0C00
`define FPF_WPL_RSV_MASK 16'hF000
`define FPF_TRAP_NUM 16'h009B
`define FPF_DUMMY_DATA 16'h0000
`define FPF_PROG_CYCLES 16
`endif

/* fpf_protect.v */
// Flash protection: fuse copies, write/access/debug gating, register port
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`include "fpf_map.vh"
module fpf_protect #(
  parameter PROG_CYCLES = `FPF_PROG_CYCLES
) (
  // System
  input wire clock,
  input wire rst,
  // Register port
  input wire [23:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output reg [15:0] rdata,
  // Flash write request from the write controller
  input wire wr_req,
  input wire [11:0] wr_sector_mask,
  output reg [11:0] wr_allow_reg,
  // CPU data access
  input wire acc_req,
  input wire acc_in_flash,
  input wire acc_is_read,
  input wire fetch_in_flash,
  output reg acc_deny_reg,
  output reg [15:0] acc_rdata_reg,
  output reg trap_reg,
  output reg [15:0] trap_num_reg,
  // Test interface
  input wire dbg_req,
  output reg dbg_enable_reg,
  output reg dbg_bypass_reg
);
  localparam ST_RESET = 2'b00;
  localparam ST_LOAD = 2'b01;
  localparam ST_RUN = 2'b10;
  localparam ST_PROG = 2'b11;
  localparam CW = 8;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [CW-1:0] cnt_reg;
  reg [15:0] stage_reg [0:4];
  reg [4:0] target_reg;
  reg wp_err_reg;
  reg acc_err_reg;
  wire [15:0] fuse [0:4];
  wire [15:0] vol [0:4];
  wire [4:0] sel;
  wire load;
  wire prog_go;
  wire wr_hit;
  reg acc_on;
  reg [15:0] prog_mask [0:4];
  integer i;
  integer j;
  integer k;
  // Decoded events shared by the gating and status logic
  wire [11:0] wp_open;
  wire acc_refuse;
  wire cmd_prog;
  wire stat_wr;
  wire clr_wp;
  wire clr_acc;
  reg loaded_reg;
  reg busy_reg;
  reg [15:0] rd_mux;

  assign load = (state_reg == ST_LOAD) && !loaded_reg;
  assign prog_go = (state_reg == ST_PROG) && (cnt_reg == {CW{1'b0}});
  assign sel[0] = (addr == `FPF_OFF_WPL) || (addr == `FPF_OFF_WPL_ALIAS);
  assign sel[1] = (addr == `FPF_OFF_WPH) || (addr == `FPF_OFF_WPH_ALIAS);
  assign sel[2] = (addr == `FPF_OFF_APM);
  assign sel[3] = (addr == `FPF_OFF_APD);
  assign sel[4] = (addr == `FPF_OFF_APE);

  // Sector map: bank 0 sectors 9:0 from the low word, 11:10 from the high word
  assign wp_open = {vol[1][1:0], vol[0][9:0]};
  assign wr_hit = wr_req && |(wr_sector_mask & ~wp_open);
  assign acc_refuse = acc_req && acc_in_flash && acc_on && !fetch_in_flash;
  assign cmd_prog = (state_reg == ST_RUN) && wr && (addr == `FPF_OFF_CMD) &&
    wdata[`FPF_CMD_PROG_BIT];
  assign stat_wr = wr && (addr == `FPF_OFF_STAT);
  assign clr_wp = stat_wr && wdata[`FPF_STAT_WPERR_BIT];
  assign clr_acc = stat_wr && wdata[`FPF_STAT_ACCERR_BIT];

  // One load per reset: a stray return to the load state cannot reread the cells
  always @(posedge clock) begin
    if (rst) begin
      loaded_reg <= 1'b0;
    end else if (load) begin
      loaded_reg <= 1'b1;
    end
  end

  // Five fuse words and their volatile copies
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : cells
      fpf_fuse_cell #(.W(16), .INIT(16'hFFFF)) u_cell (
        .clock(clock),
        .rst(rst),
        .load(load),
        .prog(prog_go && target_reg[g]),
        .temp((state_reg == ST_RUN) && wr && sel[g] &&
          (addr == `FPF_OFF_CMD) && 1'b0),
        .prog_mask(prog_mask[g]),
        .temp_data(stage_reg[g]),
        .fuse_reg(fuse[g]),
        .vol_reg(vol[g])
      );
    end
  endgenerate

  // Programming masks with the chained ordering checks
  // Own loop index per process, so no block wakes another through it
  always @* begin
    for (j = 0; j < 5; j = j + 1) begin
      prog_mask[j] = ~stage_reg[j];
    end
    prog_mask[0] = prog_mask[0] & ~`FPF_WPL_RO_MASK & ~`FPF_WPL_RSV_MASK;
    prog_mask[1] = prog_mask[1] & 16'h0003;
    prog_mask[2] = prog_mask[2] & 16'h0003;
    if (fuse[2][`FPF_APM_DBG_FUSE_BIT] || fuse[2][`FPF_APM_ACC_FUSE_BIT]) begin
      prog_mask[3][0] = 1'b0;
    end
    for (j = 1; j < 16; j = j + 1) begin
      if (fuse[4][j-1]) begin
        prog_mask[3][j] = 1'b0;
      end
    end
    for (j = 0; j < 16; j = j + 1) begin
      if (fuse[3][j]) begin
        prog_mask[4][j] = 1'b0;
      end
    end
  end

  // Chain scan: the last programmed stage decides
  always @* begin
    acc_on = ~vol[2][`FPF_APM_ACC_FUSE_BIT];
    for (k = 0; k < 16; k = k + 1) begin
      if (!vol[3][k] && vol[4][k]) begin
        acc_on = 1'b0;
      end else if (!vol[3][k] && !vol[4][k]) begin
        acc_on = ~vol[2][`FPF_APM_ACC_FUSE_BIT];
      end
    end
  end

  // Reset, load and programming sequence
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_RESET: state_next = ST_LOAD;
      ST_LOAD: state_next = ST_RUN;
      ST_RUN: begin
        if (cmd_prog) begin
          state_next = ST_PROG;
        end
      end
      ST_PROG: begin
        if (cnt_reg == {CW{1'b0}}) begin
          state_next = ST_RUN;
        end
      end
      default: state_next = ST_RESET;
    endcase
  end

  always @(posedge clock) begin
    if (rst) begin
      state_reg <= ST_RESET;
      cnt_reg <= {CW{1'b0}};
      target_reg <= 5'h00;
      for (i = 0; i < 5; i = i + 1) begin
        stage_reg[i] <= `FPF_ALL_ONES;
      end
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_RUN && wr) begin
        for (i = 0; i < 5; i = i + 1) begin
          if (sel[i]) begin
            stage_reg[i] <= wdata;
            target_reg[i] <= 1'b1;
          end
        end
        if (addr == `FPF_OFF_CMD && wdata[`FPF_CMD_PROG_BIT]) begin
          cnt_reg <= PROG_CYCLES[CW-1:0] - 8'h01;
        end
      end else if (state_reg == ST_PROG) begin
        if (cnt_reg != {CW{1'b0}}) begin
          cnt_reg <= cnt_reg - 8'h01;
        end else begin
          target_reg <= 5'h00;
          for (i = 0; i < 5; i = i + 1) begin
            stage_reg[i] <= `FPF_ALL_ONES;
          end
        end
      end
    end
  end

  // Busy flag held in its own flop so the read path sees a clean level
  always @(posedge clock) begin
    if (rst) begin
      busy_reg <= 1'b0;
    end else if (cmd_prog) begin
      busy_reg <= 1'b1;
    end else if (prog_go) begin
      busy_reg <= 1'b0;
    end
  end

  // Gating outputs; reset and load block writes and debug but clear the access denial
  always @(posedge clock) begin
    if (rst || state_reg == ST_RESET || load) begin
      wr_allow_reg <= 12'h000;
      acc_deny_reg <= 1'b0;
      acc_rdata_reg <= `FPF_DUMMY_DATA;
      trap_reg <= 1'b0;
      trap_num_reg <= `FPF_ALL_ZERO;
      dbg_enable_reg <= 1'b0;
      dbg_bypass_reg <= 1'b0;
    end else begin
      dbg_enable_reg <= vol[2][`FPF_APM_DBG_FUSE_BIT];
      dbg_bypass_reg <= dbg_req && vol[2][`FPF_APM_DBG_FUSE_BIT];
      // Multi-sector erase keeps going on the unprotected sectors
      wr_allow_reg <= wr_sector_mask & wp_open;
      acc_deny_reg <= acc_refuse;
      acc_rdata_reg <= `FPF_DUMMY_DATA;
      trap_reg <= acc_refuse && acc_is_read;
      trap_num_reg <= `FPF_TRAP_NUM;
    end
  end

  // Error flags: a new event beats a same-cycle clear
  always @(posedge clock) begin
    if (rst || state_reg == ST_RESET || load) begin
      wp_err_reg <= 1'b0;
      acc_err_reg <= 1'b0;
    end else begin
      if (wr_hit) begin
        wp_err_reg <= 1'b1;
      end else if (clr_wp) begin
        wp_err_reg <= 1'b0;
      end
      if (acc_refuse) begin
        acc_err_reg <= 1'b1;
      end else if (clr_acc) begin
        acc_err_reg <= 1'b0;
      end
    end
  end

  // Read mux: fuse words read back; low bits 11:10 follow the high word
  always @* begin
    rd_mux = `FPF_ALL_ZERO;
    if (sel[0]) begin
      rd_mux = {4'hF, fuse[1][1:0], fuse[0][9:0]};
    end else if (sel[1]) begin
      rd_mux = fuse[1];
    end else if (sel[2]) begin
      rd_mux = fuse[2];
    end else if (sel[3]) begin
      rd_mux = fuse[3];
    end else if (sel[4]) begin
      rd_mux = fuse[4];
    end else if (addr == `FPF_OFF_CTRL) begin
      rd_mux = {14'h0000, busy_reg, 1'b0};
    end else if (addr == `FPF_OFF_STAT) begin
      rd_mux = {12'h000, acc_on, dbg_enable_reg, acc_err_reg, wp_err_reg};
    end
  end

  // Read data stand for the one cycle after the strobe only
  always @(posedge clock) begin
    if (rst) begin
      rdata <= `FPF_ALL_ZERO;
    end else if (rd) begin
      rdata <= rd_mux;
    end else begin
      rdata <= `FPF_ALL_ZERO;
    end
  end
endmodule

/* fpf_protect_monitor.sv */
// Concurrent checks on the flash protection ports
`timescale 1ns/1ps
`include "fpf_map.vh"
module fpf_protect_monitor (
  // System and register port
  input wire clock, rst, rd,
  input wire [23:0] addr,
  input wire [15:0] rdata,
  // Write gating and data access
  input wire [11:0] wr_sector_mask, wr_allow_reg,
  input wire wr_req, acc_req, acc_in_flash, acc_is_read, fetch_in_flash,
  input wire acc_deny_reg, trap_reg,
  input wire [15:0] acc_rdata_reg, trap_num_reg,
  // Test interface
  input wire dbg_req, dbg_enable_reg, dbg_bypass_reg
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  a_reset_safe: assert property ($past(rst) |-> wr_allow_reg == 12'h000 ##1
    wr_allow_reg == 12'h000) else $error("write allowed after reset");
  a_wr_subset: assert property (wr_allow_reg != 12'h000 |-> $past(wr_req) &&
    (wr_allow_reg & ~$past(wr_sector_mask)) == 12'h000) else $error("sector wrongly allowed");
  a_wpl_fixed: assert property (rd && addr == `FPF_OFF_WPL |=> rdata[15:12] == 4'hF)
    else $error("reserved bits not one");
  a_alias_fixed: assert property (rd && addr == `FPF_OFF_WPL_ALIAS |=> rdata[15:12] == 4'hF)
    else $error("alias reserved bits not one");
  a_deny_cause: assert property (acc_deny_reg |-> $past(acc_req) && $past(acc_in_flash) &&
    !$past(fetch_in_flash)) else $error("access refused without cause");
  a_trap_read: assert property (trap_reg |-> acc_deny_reg && $past(acc_is_read) &&
    acc_rdata_reg == 16'h0000 && trap_num_reg == 16'h009B) else $error("bad trap");
  a_dbg_gate: assert property (dbg_bypass_reg |-> dbg_enable_reg)
    else $error("bypass with debug disabled");
  a_bypass_cause: assert property (dbg_bypass_reg == ($past(dbg_req) && dbg_enable_reg))
    else $error("bypass not following request");
endmodule
bind fpf_protect fpf_protect_monitor mon (.*);

/* tb_top.sv */
// Self-checking testbench for the flash protection logic
`timescale 1ns/1ps
`include "fpf_map.vh"
module tb_top;
  reg clock = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, wr_req = 1'b0, dbg_req = 1'b0;
  reg [23:0] addr = 24'h000000;
  reg [15:0] wdata = 16'h0000;
  reg [11:0] wr_sector_mask = 12'h000;
  wire [15:0] rdata, acc_rdata_reg, trap_num_reg;
  wire [11:0] wr_allow_reg;
  wire acc_req, acc_in_flash, acc_is_read, fetch_in_flash, acc_deny_reg, trap_reg;
  wire dbg_enable_reg, dbg_bypass_reg;
  integer fail_count = 0, n_checks = 0;
  always #5 clock = ~clock;
  fpf_protect #(.PROG_CYCLES(4)) dut (.*);
  fpf_cpu_model cpu (.*);
  task chk(input [15:0] s, input [15:0] e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task bw(input [23:0] a, input [15:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task rchk(input [23:0] a, input [15:0] m, input [15:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(rdata & m, e);
  endtask
  // Stage a word, launch programming, see busy rise and fall
  task prog(input [23:0] a, input [15:0] v);
    bw(a, v);
    bw(`FPF_OFF_CMD, 16'h0001);
    rchk(`FPF_OFF_CTRL, 16'h0002, 16'h0002);
    repeat (6) @(posedge clock);
    rchk(`FPF_OFF_CTRL, 16'h0002, 16'h0000);
  endtask
  task wchk(input [11:0] m, input [11:0] e);
    @(posedge clock);
    wr_sector_mask <= m;
    @(posedge clock);
    #1 chk({4'h0, wr_allow_reg}, {4'h0, e});
  endtask
  task achk(input f, input r, input [1:0] e);
    cpu.access(f, r);
    #1 chk({14'h0000, acc_deny_reg, trap_reg}, {14'h0000, e});
  endtask
  task results;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clock);
    fail_count++;
    results;
  end
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    repeat (3) @(posedge clock);
    dbg_req <= 1'b1;
    wr_req <= 1'b1;
    rchk(`FPF_OFF_WPL, 16'hFFFF, 16'hFFFF);
    rchk(24'h0EDFD0, 16'hFFFF, 16'h0000);
    chk({15'h0000, dbg_bypass_reg}, 16'h0001);
    wchk(12'hFFF, 12'hFFF);
    achk(1'b0, 1'b1, 2'b00);
    prog(`FPF_OFF_WPL, 16'hFFFE);
    rchk(`FPF_OFF_WPL_ALIAS, 16'hFFFF, 16'hFFFE);
    prog(`FPF_OFF_WPL_ALIAS, 16'hFFFF);
    rchk(`FPF_OFF_WPL, 16'hFFFF, 16'hFFFE);
    prog(`FPF_OFF_WPH_ALIAS, 16'hFFFD);
    rchk(`FPF_OFF_WPH, 16'hFFFF, 16'hFFFD);
    rchk(`FPF_OFF_WPL, 16'hFFFF, 16'hF7FE);
    wchk(12'hFFF, 12'h7FE);
    rchk(`FPF_OFF_STAT, 16'h000F, 16'h0005);
    wchk(12'h000, 12'h000);
    bw(`FPF_OFF_STAT, 16'h0001);
    rchk(`FPF_OFF_STAT, 16'h000F, 16'h0004);
    prog(`FPF_OFF_APM, 16'hFFFE);
    achk(1'b0, 1'b1, 2'b11);
    chk(trap_num_reg, `FPF_TRAP_NUM);
    chk(acc_rdata_reg, `FPF_DUMMY_DATA);
    achk(1'b0, 1'b0, 2'b10);
    achk(1'b1, 1'b1, 2'b00);
    prog(`FPF_OFF_APD, 16'hFFFE);
    rchk(`FPF_OFF_APD, 16'hFFFF, 16'hFFFF);
    prog(`FPF_OFF_APM, 16'hFFFC);
    chk({14'h0000, dbg_enable_reg, dbg_bypass_reg}, 16'h0000);
    prog(`FPF_OFF_APD, 16'hFFFC);
    rchk(`FPF_OFF_APD, 16'hFFFF, 16'hFFFE);
    achk(1'b0, 1'b1, 2'b00);
    prog(`FPF_OFF_APE, 16'hFFFE);
    achk(1'b0, 1'b1, 2'b11);
    results;
  end
endmodule
